// [verilog/seg_lcd_pkg.sv]
// Constants and types shared by the segment display driver
package seg_lcd_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [9:0] IDX_DUTY_CLK = 10'h0_099;
  localparam logic [9:0] IDX_OUTPUT = 10'h0_09a;
  localparam logic [9:0] IDX_CONTRAST = 10'h0_09b;
  localparam logic [9:0] IDX_STATUS = 10'h0_09c;
  localparam logic [7:0] RST_DUTY_CLK = 8'h00;
  localparam logic [7:0] RST_OUTPUT = 8'h00;
  localparam logic [7:0] RST_CONTRAST = 8'h00;
  // Field positions
  localparam int OUT_DISPLAY_ON = 0;
  localparam int OUT_BIAS_SRC = 1;
  localparam int OUT_RELOCATE = 4;
  localparam int DC_CLK_LSB = 0;
  localparam int DC_DBS_LSB = 2;
  localparam int CC_STEP_LSB = 0;
  localparam int CC_ENABLE = 7;
  // Duty/bias codes
  localparam logic [3:0] DBS_D8_B4 = 4'h0;
  localparam logic [3:0] DBS_D6_B4 = 4'h1;
  localparam logic [3:0] DBS_D5_B3 = 4'h2;
  localparam logic [3:0] DBS_D4_B3 = 4'h3;
  localparam logic [3:0] DBS_D3_B3 = 4'h4;
  localparam logic [3:0] DBS_D3_B2 = 4'h5;
  localparam logic [3:0] DBS_D3_B2_HI = 4'h6;
  localparam logic [3:0] DBS_D2_B2 = 4'h7;
  localparam logic [3:0] DBS_D2_B2_HI = 4'h8;
  // Contrast bases: top level = VDD * num / (base - step)
  localparam logic [4:0] B4_NUM = 5'h10;
  localparam logic [4:0] B4_BASE = 5'h1f;
  localparam logic [4:0] B3_NUM = 5'h0c;
  localparam logic [4:0] B3_BASE = 5'h1b;
  localparam logic [4:0] B2_NUM = 5'h08;
  localparam logic [4:0] B2_BASE = 5'h17;
  // Watch clock 32768 Hz; 256 ticks give 128 Hz at select 0
  localparam logic [7:0] SCAN_DIV_MAX = 8'hff;
  // Display memory window
  localparam logic [15:0] MEM_FIRST = 16'h0000;
  localparam logic [15:0] MEM_LAST = 16'h001a;
  localparam int SEG_COUNT = 27;
  typedef enum logic [1:0] {FETCH_IDLE, FETCH_READ} fetch_state_t;
endpackage

// [verilog/lcd_ctl_if.sv]
// Control settings and status between register slave and display core
`timescale 1ns/1ps
interface lcd_ctl_if;
  logic [7:0] duty_clk;
  logic [7:0] out_ctl;
  logic [7:0] contrast;
  logic [7:0] status;
  modport regs (output duty_clk, output out_ctl, output contrast, input status);
  modport core (input duty_clk, input out_ctl, input contrast, output status);
endinterface

// [verilog/lcd_wb_regs.sv]
// Wishbone classic slave holding the display control registers
`timescale 1ns/1ps
module lcd_wb_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  lcd_ctl_if.regs ctl
);
  import seg_lcd_pkg::*;

  logic [7:0] duty_clk_r, duty_clk_nxt;
  logic [7:0] out_ctl_r, out_ctl_nxt;
  logic [7:0] contrast_r, contrast_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic ack_r, ack_nxt;
  logic req;
  logic [9:0] idx;

  assign req = cyc_i && stb_i && !ack_r;
  assign idx = adr_i[11:2];

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    duty_clk_nxt = duty_clk_r;
    out_ctl_nxt = out_ctl_r;
    contrast_nxt = contrast_r;
    dat_nxt = dat_r;
    ack_nxt = req;
    if (req && we_i && sel_i[0]) begin
      // Unused bits stay zero so they read back as zero
      unique case (idx)
        IDX_DUTY_CLK: duty_clk_nxt = {2'b00, dat_i[5:0]};
        IDX_OUTPUT: out_ctl_nxt = {3'b000, dat_i[4], 2'b00, dat_i[1:0]};
        IDX_CONTRAST: contrast_nxt = {dat_i[7], 3'b000, dat_i[3:0]};
        default: ;
      endcase
    end
    if (req && !we_i) begin
      unique case (idx)
        IDX_DUTY_CLK: dat_nxt = {24'h00_0000, duty_clk_r};
        IDX_OUTPUT: dat_nxt = {24'h00_0000, out_ctl_r};
        IDX_CONTRAST: dat_nxt = {24'h00_0000, contrast_r};
        IDX_STATUS: dat_nxt = {24'h00_0000, ctl.status};
        default: dat_nxt = 32'h0000_0000;
      endcase
    end
    if (rst_i) begin
      duty_clk_nxt = RST_DUTY_CLK;
      out_ctl_nxt = RST_OUTPUT;
      contrast_nxt = RST_CONTRAST;
      dat_nxt = 32'h0000_0000;
      ack_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    duty_clk_r <= duty_clk_nxt;
    out_ctl_r <= out_ctl_nxt;
    contrast_r <= contrast_nxt;
    dat_r <= dat_nxt;
    ack_r <= ack_nxt;
  end

  assign ctl.duty_clk = duty_clk_r;
  assign ctl.out_ctl = out_ctl_r;
  assign ctl.contrast = contrast_r;
  assign dat_o = dat_r;
  assign ack_o = ack_r;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  property p_ack_next;
    s_req |=> ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
  property p_reset_clear;
    disable iff (1'b0) $past(rst_i) |-> (duty_clk_r == 8'h00 && out_ctl_r == 8'h00
      && contrast_r == 8'h00);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left a setting");
endmodule

// [verilog/seg_lcd_driver.sv]
// Segment display driver: scan timing, memory fetch, pin and bias control
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
module seg_lcd_driver (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic watch_timer_clock_i,
  input wire logic stop_mode_i,
  input wire logic sub_clock_i,
  input wire logic [3:0] port3_function_select_i,
  output logic [15:0] mem_addr_o,
  output logic mem_rd_o,
  input wire logic [7:0] mem_data_i,
  input wire logic mem_ack_i,
  output logic [7:0] com_o,
  output logic [seg_lcd_pkg::SEG_COUNT-1:0] seg_o,
  output logic frame_polarity_o,
  output logic [3:0] port3_upper_pins_o,
  output logic [3:0] port3_upper_oe_n_o,
  output logic [3:0] port3_lower_pins_o,
  output logic [3:0] port3_lower_oe_n_o,
  output logic bias_external_o,
  output logic [2:0] bias_den_o,
  output logic res_120k_o,
  output logic [4:0] top_bias_num_o,
  output logic [4:0] top_bias_den_o
);
  import seg_lcd_pkg::*;

  lcd_ctl_if ctl ();

  lcd_wb_regs u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .ctl(ctl.regs)
  );

  ////////////////////////////////////////////////////////////////////////
  // Settings decode
  logic display_on, relocate, contrast_enable;
  logic [3:0] duty_bias_select, contrast_step;
  logic [1:0] frame_clock_select;
  logic [3:0] com_count;
  logic [2:0] bias_den;
  logic code_ok, relocate_ok, halted, active;

  assign display_on = ctl.out_ctl[OUT_DISPLAY_ON];
  assign relocate = ctl.out_ctl[OUT_RELOCATE];
  assign duty_bias_select = ctl.duty_clk[DC_DBS_LSB +: 4];
  assign frame_clock_select = ctl.duty_clk[DC_CLK_LSB +: 2];
  assign contrast_enable = ctl.contrast[CC_ENABLE];
  assign contrast_step = ctl.contrast[CC_STEP_LSB +: 4];

  always_comb begin
    code_ok = 1'b1;
    res_120k_o = 1'b0;
    unique case (duty_bias_select)
      DBS_D8_B4: begin com_count = 4'd8; bias_den = 3'd4; end
      DBS_D6_B4: begin com_count = 4'd6; bias_den = 3'd4; end
      DBS_D5_B3: begin com_count = 4'd5; bias_den = 3'd3; end
      DBS_D4_B3: begin com_count = 4'd4; bias_den = 3'd3; end
      DBS_D3_B3: begin com_count = 4'd3; bias_den = 3'd3; end
      DBS_D3_B2: begin com_count = 4'd3; bias_den = 3'd2; end
      DBS_D3_B2_HI: begin com_count = 4'd3; bias_den = 3'd2; res_120k_o = 1'b1; end
      DBS_D2_B2: begin com_count = 4'd2; bias_den = 3'd2; end
      DBS_D2_B2_HI: begin com_count = 4'd2; bias_den = 3'd2; res_120k_o = 1'b1; end
      default: begin com_count = 4'd2; bias_den = 3'd2; code_ok = 1'b0; end
    endcase
  end

  // Unavailable codes blank the glass rather than guess a waveform
  assign active = display_on && code_ok;
  // Stop without the sub clock freezes the scan; idle does not matter here
  assign halted = stop_mode_i && !sub_clock_i;
  assign relocate_ok = relocate && (com_count <= 4'd4);
  assign bias_external_o = ctl.out_ctl[OUT_BIAS_SRC];
  assign bias_den_o = bias_den;

  // Contrast: top bias level = VDD * num / den
  always_comb begin
    top_bias_num_o = 5'h01;
    top_bias_den_o = 5'h01;
    if (contrast_enable) begin
      unique case (bias_den)
        3'd4: begin top_bias_num_o = B4_NUM; top_bias_den_o = B4_BASE - {1'b0, contrast_step}; end
        3'd3: begin top_bias_num_o = B3_NUM; top_bias_den_o = B3_BASE - {1'b0, contrast_step}; end
        default: begin top_bias_num_o = B2_NUM; top_bias_den_o = B2_BASE - {1'b0, contrast_step}; end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Watch clock sync and scan divider
  logic wck_s1_r, wck_s2_r, wck_s3_r;
  logic [7:0] div_r, div_nxt;
  logic [2:0] com_idx_r, com_idx_nxt;
  logic pol_r, pol_nxt;
  logic wck_tick, scan_tick, frame_start;
  logic [7:0] div_max;

  always_ff @(posedge clk_i) begin
    wck_s1_r <= watch_timer_clock_i;
    wck_s2_r <= wck_s1_r;
    wck_s3_r <= wck_s2_r;
  end

  assign wck_tick = wck_s2_r && !wck_s3_r;
  assign div_max = SCAN_DIV_MAX >> frame_clock_select;
  assign scan_tick = wck_tick && (div_r >= div_max);
  assign frame_start = scan_tick && ({1'b0, com_idx_r} == com_count - 4'd1);

  always_comb begin
    div_nxt = div_r;
    com_idx_nxt = com_idx_r;
    pol_nxt = pol_r;
    if (!active) begin
      div_nxt = 8'h00;
      com_idx_nxt = 3'd0;
    end else if (!halted && wck_tick) begin
      div_nxt = scan_tick ? 8'h00 : div_r + 8'h01;
      if (scan_tick) begin
        com_idx_nxt = frame_start ? 3'd0 : com_idx_r + 3'd1;
        pol_nxt = frame_start ? !pol_r : pol_r;
      end
    end
    if (rst_i) begin
      div_nxt = 8'h00;
      com_idx_nxt = 3'd0;
      pol_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    div_r <= div_nxt;
    com_idx_r <= com_idx_nxt;
    pol_r <= pol_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Display memory fetch, one pass per frame
  fetch_state_t fst_r, fst_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [7:0] seg_mem [SEG_COUNT];
  logic kick_r, kick_nxt;

  always_comb begin
    fst_nxt = fst_r;
    addr_nxt = addr_r;
    // First pass right after turning on, then every frame
    // Kick is spent only when a pass starts, so a halted turn-on still fetches later
    kick_nxt = active ? kick_r : 1'b0;
    unique case (fst_r)
      FETCH_IDLE: begin
        if (active && !halted && (frame_start || (active && !kick_r))) begin
          fst_nxt = FETCH_READ;
          addr_nxt = MEM_FIRST;
          kick_nxt = 1'b1;
        end
      end
      FETCH_READ: begin
        if (!active) begin
          fst_nxt = FETCH_IDLE;
        end else if (mem_ack_i) begin
          if (addr_r == MEM_LAST) fst_nxt = FETCH_IDLE;
          else addr_nxt = addr_r + 16'h0001;
        end
      end
    endcase
    if (rst_i) begin
      fst_nxt = FETCH_IDLE;
      addr_nxt = MEM_FIRST;
      kick_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    fst_r <= fst_nxt;
    addr_r <= addr_nxt;
    kick_r <= kick_nxt;
    if (fst_r == FETCH_READ && mem_ack_i) begin
      seg_mem[addr_r[4:0]] <= mem_data_i;
    end
  end

  assign mem_rd_o = (fst_r == FETCH_READ);
  assign mem_addr_o = addr_r;

  ////////////////////////////////////////////////////////////////////////
  // Electrode drive
  logic [7:0] com_nxt, com_r;
  logic [SEG_COUNT-1:0] seg_nxt, seg_r;

  always_comb begin
    com_nxt = 8'h00;
    seg_nxt = '0;
    if (active && !rst_i) begin
      com_nxt = 8'h01 << com_idx_r;
      for (int i = 0; i < SEG_COUNT; i++) begin
        seg_nxt[i] = seg_mem[i][com_idx_r];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    com_r <= com_nxt;
    seg_r <= seg_nxt;
  end

  assign com_o = com_r;
  assign seg_o = seg_r;
  assign frame_polarity_o = pol_r;

  // Commons 0..3 go to upper pins, or reversed onto the lower pins; relocating above four commons drives neither
  always_comb begin
    port3_upper_pins_o = com_r[3:0];
    port3_upper_oe_n_o = relocate ? 4'hf : 4'h0;
    for (int k = 0; k < 4; k++) begin
      port3_lower_pins_o[k] = com_r[3 - k];
      port3_lower_oe_n_o[k] = !(relocate_ok && port3_function_select_i[k]);
    end
  end

  assign ctl.status = {fst_r == FETCH_READ, active, halted, 2'b00, com_idx_r};

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_lower_gate;
    !port3_lower_oe_n_o[0] |-> relocate && port3_function_select_i[0];
  endproperty
  a_lower_gate: assert property (p_lower_gate) else $error("lower pin driven wrongly");
  property p_relocate_duty;
    port3_lower_oe_n_o != 4'hf |-> com_count <= 4'd4;
  endproperty
  a_relocate_duty: assert property (p_relocate_duty) else $error("relocated at fine duty");
  property p_upper;
    !relocate |-> port3_upper_oe_n_o == 4'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper pins not driven");
  property p_off_blank;
    !display_on ##1 !display_on |-> com_o == 8'h00 && seg_o == '0 && !mem_rd_o;
  endproperty
  a_off_blank: assert property (p_off_blank) else $error("display off not blank");
  property p_bad_code;
    duty_bias_select > DBS_D2_B2_HI |=> com_o == 8'h00;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("unavailable code drove commons");
  property p_contrast_off;
    !contrast_enable |-> top_bias_num_o == top_bias_den_o;
  endproperty
  a_contrast_off: assert property (p_contrast_off) else $error("contrast active when off");
  property p_quarter;
    contrast_enable && bias_den == 3'd4 |-> top_bias_den_o == 5'd31 - {1'b0, contrast_step};
  endproperty
  a_quarter: assert property (p_quarter) else $error("quarter bias ratio wrong");
  property p_fetch_range;
    mem_rd_o |-> mem_addr_o <= MEM_LAST;
  endproperty
  a_fetch_range: assert property (p_fetch_range) else $error("fetch outside window");
  property p_stop_hold;
    halted && $stable(ctl.out_ctl) && $stable(ctl.duty_clk) |=> $stable(com_idx_r);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("scan moved while stopped");
endmodule

// [dv/display_mem_model.sv]
// Display memory model answering the driver's fetch port
`timescale 1ns/1ps
module display_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic mem_rd_i,
  input wire logic [15:0] mem_addr_i,
  output logic [7:0] mem_data_o,
  output logic mem_ack_o,
  output logic [15:0] rd_count_o,
  output logic order_err_o
);
  logic [1:0] wait_r;
  logic [15:0] last_r;
  ////////////////////////////////////////////////////////////////
  // Data toggles outside the ack cycle, so a late sample is caught
  always_ff @(posedge clk_i) begin
    mem_data_o <= ~mem_data_o;
    mem_ack_o <= 1'b0;
    if (rst_i) begin
      wait_r <= 2'h0;
      last_r <= 16'h0000;
      rd_count_o <= 16'h0000;
      order_err_o <= 1'b0;
    end else if (mem_rd_i && !mem_ack_o) begin
      if (wait_r == {slow_i, slow_i}) begin
        mem_ack_o <= 1'b1;
        mem_data_o <= mem_addr_i[7:0] * 8'h25 ^ 8'h5a;
        rd_count_o <= rd_count_o + 16'h0001;
        last_r <= mem_addr_i;
        wait_r <= 2'h0;
        // Ascending from zero, never past the last byte
        if (mem_addr_i > 16'h001a || (mem_addr_i != 16'h0000 && mem_addr_i != last_r + 16'h0001))
          order_err_o <= 1'b1;
      end else begin
        wait_r <= wait_r + 2'h1;
      end
    end
  end
endmodule

// [dv/tb_top.sv]
// Self-checking bench for the segment display driver
`timescale 1ns/1ps
module tb_top;
  import seg_lcd_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, wclk = 1'b0, stop = 1'b0, sub = 1'b0, slow = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] fsel = 4'h0, up_p, up_oe, lo_p, lo_oe;
  logic [3:0] sel = 4'h1;
  logic [31:0] wdat = 32'h0000_0000, rdat, dat_o;
  logic ack_o, mem_rd_o, mem_ack_i, pol, ext, r120, order_err;
  logic [15:0] mem_addr_o, rd_count;
  logic [7:0] mem_data_i, com_o;
  logic [SEG_COUNT-1:0] seg_o, exp_seg;
  logic [2:0] bias_den_o;
  logic [4:0] num, den;
  int n_errors = 0;
  int check_count = 0;
  int wticks = 0;
  initial forever #10 clk_i = ~clk_i;
  // Watch clock kept running, phase unrelated to the system clock
  initial forever #83 wclk = ~wclk;
  always @(posedge wclk) wticks++;
  ////////////////////////////////////////////////////////////////
  seg_lcd_driver seg_lcd_driver_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
    .watch_timer_clock_i(wclk), .stop_mode_i(stop), .sub_clock_i(sub),
    .port3_function_select_i(fsel), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
    .mem_data_i(mem_data_i), .mem_ack_i(mem_ack_i), .com_o(com_o), .seg_o(seg_o),
    .frame_polarity_o(pol), .port3_upper_pins_o(up_p), .port3_upper_oe_n_o(up_oe),
    .port3_lower_pins_o(lo_p), .port3_lower_oe_n_o(lo_oe), .bias_external_o(ext),
    .bias_den_o(bias_den_o), .res_120k_o(r120), .top_bias_num_o(num), .top_bias_den_o(den));
  display_mem_model display_mem_model_i (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
    .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o), .mem_data_o(mem_data_i),
    .mem_ack_o(mem_ack_i), .rd_count_o(rd_count), .order_err_o(order_err));
  ////////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic cycle; request held until ack is seen
  task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h00_0000, d};
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack_o !== 1'b1 && i < 50);
    if (ack_o !== 1'b1) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, ack_o, 1'b1);
      finish_test();
    end
    // Released at the edge where ack was sampled; next call adds the idle cycle
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wait_com;
    logic [7:0] c;
    int i;
    c = com_o;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (com_o === c && i < 5000);
    if (com_o === c) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, com_o, ~c);
      finish_test();
    end
    repeat (2) @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic s_reset;
    wb(1'b0, IDX_DUTY_CLK, 8'h00);
    chk(rdat, 32'h0000_0000);
    wb(1'b0, IDX_OUTPUT, 8'h00);
    chk(rdat, 32'h0000_0000);
    wb(1'b0, IDX_CONTRAST, 8'h00);
    chk(rdat, 32'h0000_0000);
    wb(1'b1, 10'h0a0, 8'h5a);
    wb(1'b0, 10'h0a0, 8'h00);
    chk(rdat, 32'h0000_0000);
    // Write without the low byte select must be ignored
    sel <= 4'h0;
    wb(1'b1, IDX_CONTRAST, 8'h85);
    sel <= 4'h1;
    wb(1'b0, IDX_CONTRAST, 8'h00);
    chk(rdat, 32'h0000_0000);
    chk({com_o, mem_rd_o}, 32'h0000_0000);
  endtask
  // Every legal duty code: bias divider and resistor choice
  task automatic s_duty;
    for (int c = 0; c < 9; c++) begin
      wb(1'b1, IDX_DUTY_CLK, 8'(c << 2));
      chk(bias_den_o, c < 2 ? 4 : (c < 5 ? 3 : 2));
      chk(r120, (c == 6 || c == 8));
    end
    wb(1'b1, IDX_OUTPUT, 8'h02);
    chk(ext, 1'b1);
    wb(1'b0, IDX_OUTPUT, 8'h00);
    chk(rdat, 32'h0000_0002);
    wb(1'b1, IDX_OUTPUT, 8'h00);
    chk(ext, 1'b0);
  endtask
  task automatic s_contrast;
    logic [3:0] code [3] = '{4'h0, 4'h2, 4'h5};
    wb(1'b1, IDX_CONTRAST, 8'h05);
    chk({num, den}, {5'h01, 5'h01});
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, IDX_DUTY_CLK, {2'b00, code[i], 2'b00});
      wb(1'b1, IDX_CONTRAST, 8'h85);
      chk({num, den}, {5'(16 - 4 * i), 5'(26 - 4 * i)});
    end
    wb(1'b1, IDX_DUTY_CLK, 8'h00);
    wb(1'b1, IDX_CONTRAST, 8'h8f);
    chk({num, den}, {5'h10, 5'h10});
    wb(1'b1, IDX_CONTRAST, 8'h00);
  endtask
  // Slow memory; whole pass in order, then segments per common
  task automatic s_fetch;
    int i;
    int c;
    slow <= 1'b1;
    wb(1'b1, IDX_DUTY_CLK, 8'h0f);
    wb(1'b1, IDX_OUTPUT, 8'h01);
    i = 0;
    while (rd_count < 16'd27 && i < 3000) begin
      @(posedge clk_i);
      i++;
    end
    chk(rd_count >= 16'd27, 1'b1);
    chk(order_err, 1'b0);
    repeat (2) begin
      wait_com();
      c = 0;
      for (int k = 0; k < 4; k++)
        if (com_o[k]) c = k;
      for (int s = 0; s < SEG_COUNT; s++)
        exp_seg[s] = (8'(s) * 8'h25 ^ 8'h5a) >> c;
      chk(seg_o, exp_seg);
    end
    slow <= 1'b0;
  endtask
  // Common step period in watch ticks per clock select
  task automatic s_scan;
    int t0;
    int d;
    for (int s = 0; s < 4; s++) begin
      wb(1'b1, IDX_DUTY_CLK, 8'(12 + s));
      wait_com();
      wait_com();
      t0 = wticks;
      wait_com();
      d = wticks - t0 - (256 >> s);
      chk(d >= -1 && d <= 1, 1'b1);
    end
  endtask
  task automatic s_reloc;
    fsel <= 4'b1010;
    wb(1'b1, IDX_OUTPUT, 8'h11);
    wait_com();
    chk(lo_oe, 4'b0101);
    chk(up_oe, 4'hf);
    chk(lo_p, {com_o[0], com_o[1], com_o[2], com_o[3]});
    wb(1'b1, IDX_DUTY_CLK, 8'h03);
    chk(lo_oe, 4'hf);
    wb(1'b1, IDX_OUTPUT, 8'h01);
    wait_com();
    chk({up_oe, lo_oe}, 8'h0f);
    chk(up_p, com_o[3:0]);
  endtask
  task automatic s_stop;
    logic [7:0] c;
    wb(1'b1, IDX_DUTY_CLK, 8'h0f);
    stop <= 1'b1;
    repeat (8) @(posedge clk_i);
    c = com_o;
    repeat (1200) @(posedge clk_i);
    chk(com_o, c);
    wb(1'b0, IDX_STATUS, 8'h00);
    chk(rdat[5], 1'b1);
    sub <= 1'b1;
    wait_com();
    stop <= 1'b0;
    sub <= 1'b0;
  endtask
  // Unavailable code blanks, display off blanks, then a reset in mid-run
  task automatic s_off;
    wb(1'b1, IDX_DUTY_CLK, 8'h3c);
    repeat (4) @(posedge clk_i);
    chk(com_o, 8'h00);
    wb(1'b0, IDX_STATUS, 8'h00);
    chk(rdat[7:5], 3'h0);
    wb(1'b1, IDX_OUTPUT, 8'h00);
    repeat (4) @(posedge clk_i);
    chk(com_o, 8'h00);
    chk({seg_o, mem_rd_o}, 28'h000_0000);
    wb(1'b1, IDX_CONTRAST, 8'h8f);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, IDX_DUTY_CLK, 8'h00);
    chk(rdat, 32'h0000_0000);
    wb(1'b0, IDX_CONTRAST, 8'h00);
    chk(rdat, 32'h0000_0000);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    s_reset();
    s_duty();
    s_contrast();
    s_fetch();
    s_scan();
    s_reloc();
    s_stop();
    s_off();
    finish_test();
  end
endmodule
